// file: hw/umcg_top.sv
// Purpose: mode-control, guard-time and prescaler slice of a serial transceiver
// Assumes: status events arrive as one-cycle pulses on REF_CLK_IN; pins are synchronised here
// Notes: APB slave, zero wait states, unmapped reads return zero and are ignored
`timescale 1ns/1ps
module umcg_top #(
    parameter bit FULL_FEATURE = 1'b1
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic SRST_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // modem pins
    input wire logic CTS_N_IN,
    output logic RTS_N_OUT,
    // frame engine events and levels
    input wire logic CTS_CHANGE_IN,
    input wire logic FRAMING_ERR_IN,
    input wire logic OVERRUN_ERR_IN,
    input wire logic NOISE_ERR_IN,
    input wire logic PARITY_ERR_IN,
    input wire logic FRAME_DONE_IN,
    input wire logic BAUD_TICK_IN,
    input wire logic RX_FULL_IN,
    input wire logic TX_EMPTY_IN,
    input wire logic RX_READY_IN,
    // frame engine controls
    output logic TX_ALLOWED_OUT,
    output logic TX_COMPLETE_SET_OUT,
    output logic SEND_NACK_OUT,
    output logic SMARTCARD_MODE_OUT,
    output logic HALF_DUPLEX_OUT,
    output logic IR_ENABLE_OUT,
    output logic IR_LOW_POWER_OUT,
    output logic IR_LP_TICK_OUT,
    output logic CARD_CLK_OUT,
    // dma requests
    output logic DMA_TX_REQ_OUT,
    output logic DMA_RX_REQ_OUT,
    // interrupt
    output logic IRQ_OUT
);
    typedef struct packed {
        logic [umcg_pkg::MC_WIDTH-1:0] mode;
        logic [umcg_pkg::GT_WIDTH-1:0] gtp;
        logic [umcg_pkg::IRQ_BITS-1:0] stat;
        logic [umcg_pkg::IRQ_BITS-1:0] mask;
        logic [31:0] rdata;
        logic cts_s1;
        logic cts_s2;
        logic rts_n;
        logic nack;
        logic card_clk;
        logic dma_tx;
        logic dma_rx;
    } umcg_state_t;

    umcg_state_t st_r;
    umcg_state_t st_nxt;

    logic [umcg_pkg::MC_WIDTH-1:0] mode_eff;
    logic lp_tick;
    logic card_tick;
    logic txc_set;
    logic [8:0] lp_div;
    logic [8:0] card_div;
    logic wr_en;
    logic rd_en;
    logic [umcg_pkg::IRQ_BITS-1:0] events;

    // one decoder shared by write and read paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction

    // reduced instances hide the advanced bits from all logic except the register readback, which returns the written mode
    always_comb begin
        mode_eff = st_r.mode;
        if (!FULL_FEATURE) begin
            mode_eff[umcg_pkg::BIT_CTS_IRQ_EN] = 1'b0;
            mode_eff[umcg_pkg::BIT_CTS_FLOW_EN] = 1'b0;
            mode_eff[umcg_pkg::BIT_RTS_FLOW_EN] = 1'b0;
            mode_eff[umcg_pkg::BIT_SMARTCARD_EN] = 1'b0;
            mode_eff[umcg_pkg::BIT_SC_NACK_EN] = 1'b0;
        end
    end

    assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd_en = PSEL_IN && PENABLE_IN && !PWRITE_IN;

    // a zero prescaler is reserved; treat it as one rather than stall
    assign lp_div = (st_r.gtp[7:0] == 8'h00) ? 9'h001 : {1'b0, st_r.gtp[7:0]};
    // tick at twice the card clock rate so a toggle gives divide by 2*n
    assign card_div = (st_r.gtp[4:0] == 5'h00) ? 9'h001 : {4'h0, st_r.gtp[4:0]};

    umcg_clkdiv u_lp_div (
        .clk_in(REF_CLK_IN),
        .srst_in(SRST_IN),
        .run_in(mode_eff[umcg_pkg::BIT_IR_EN] && mode_eff[umcg_pkg::BIT_IR_LOW_POWER]),
        .div_in(lp_div),
        .tick_out(lp_tick)
    );

    umcg_clkdiv u_card_div (
        .clk_in(REF_CLK_IN),
        .srst_in(SRST_IN),
        .run_in(mode_eff[umcg_pkg::BIT_SMARTCARD_EN]),
        .div_in(card_div),
        .tick_out(card_tick)
    );

    umcg_guard u_guard (
        .clk_in(REF_CLK_IN),
        .srst_in(SRST_IN),
        .enable_in(mode_eff[umcg_pkg::BIT_SMARTCARD_EN]),
        .guard_in(FULL_FEATURE ? st_r.gtp[15:8] : 8'h00),
        .baud_tick_in(BAUD_TICK_IN),
        .frame_done_in(FRAME_DONE_IN),
        .txc_set_out(txc_set)
    );

    always_comb begin
        events = '0;
        events[umcg_pkg::IRQ_CTS] = CTS_CHANGE_IN;
        events[umcg_pkg::IRQ_ERR] = mode_eff[umcg_pkg::BIT_DMA_RX_EN]
            && (FRAMING_ERR_IN || OVERRUN_ERR_IN || NOISE_ERR_IN);
        events[umcg_pkg::IRQ_TXC] = txc_set;
        events[umcg_pkg::IRQ_NACK] = st_r.nack;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.cts_s1 = CTS_N_IN;
        st_nxt.cts_s2 = st_r.cts_s1;
        // register writes take effect at the access-phase edge
        if (wr_en) begin
            if (hit(PADDR_IN, umcg_pkg::ADDR_MODE_CONTROL_THREE)) begin
                st_nxt.mode = PWDATA_IN[umcg_pkg::MC_WIDTH-1:0];
            end
            if (hit(PADDR_IN, umcg_pkg::ADDR_GUARD_AND_PRESCALE)) begin
                st_nxt.gtp = PWDATA_IN[umcg_pkg::GT_WIDTH-1:0];
            end
            if (hit(PADDR_IN, umcg_pkg::ADDR_IRQ_MASK)) begin
                st_nxt.mask = PWDATA_IN[umcg_pkg::IRQ_BITS-1:0];
            end
        end
        // read data is captured in setup so it stands registered in access
        st_nxt.rdata = 32'h0000_0000;
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            if (hit(PADDR_IN, umcg_pkg::ADDR_MODE_CONTROL_THREE)) begin
                st_nxt.rdata[umcg_pkg::MC_WIDTH-1:0] = st_r.mode;
            end
            if (hit(PADDR_IN, umcg_pkg::ADDR_GUARD_AND_PRESCALE)) begin
                st_nxt.rdata[umcg_pkg::GT_WIDTH-1:0] = st_r.gtp;
            end
            if (hit(PADDR_IN, umcg_pkg::ADDR_IRQ_STATUS)) begin
                st_nxt.rdata[umcg_pkg::IRQ_BITS-1:0] = st_r.stat | events;
            end
            if (hit(PADDR_IN, umcg_pkg::ADDR_IRQ_MASK)) begin
                st_nxt.rdata[umcg_pkg::IRQ_BITS-1:0] = st_r.mask;
            end
            if (hit(PADDR_IN, umcg_pkg::ADDR_LINK_STATUS)) begin
                st_nxt.rdata[3:0] = {RX_FULL_IN, TX_EMPTY_IN, st_r.rts_n, st_r.cts_s2};
            end
        end
        // read clears status; a same-cycle event still sets its bit
        if (rd_en && hit(PADDR_IN, umcg_pkg::ADDR_IRQ_STATUS)) begin
            st_nxt.stat = events;
        end else begin
            st_nxt.stat = st_r.stat | events;
        end
        // receive flow: high while the receiver cannot take a character
        if (mode_eff[umcg_pkg::BIT_RTS_FLOW_EN]) begin
            st_nxt.rts_n = !RX_READY_IN;
        end else begin
            st_nxt.rts_n = 1'b0;
        end
        st_nxt.nack = mode_eff[umcg_pkg::BIT_SMARTCARD_EN]
            && mode_eff[umcg_pkg::BIT_SC_NACK_EN] && PARITY_ERR_IN;
        if (!mode_eff[umcg_pkg::BIT_SMARTCARD_EN]) begin
            st_nxt.card_clk = 1'b0;
        end else if (card_tick) begin
            st_nxt.card_clk = !st_r.card_clk;
        end
        st_nxt.dma_tx = mode_eff[umcg_pkg::BIT_DMA_TX_EN] && TX_EMPTY_IN;
        st_nxt.dma_rx = mode_eff[umcg_pkg::BIT_DMA_RX_EN] && RX_FULL_IN;
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (SRST_IN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA_OUT = st_r.rdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = 1'b0;
    assign RTS_N_OUT = st_r.rts_n;
    // with flow control off the pin is ignored by the send gate; it still reads back in link status
    assign TX_ALLOWED_OUT = !mode_eff[umcg_pkg::BIT_CTS_FLOW_EN] || !st_r.cts_s2;
    assign TX_COMPLETE_SET_OUT = txc_set;
    assign SEND_NACK_OUT = st_r.nack;
    assign SMARTCARD_MODE_OUT = mode_eff[umcg_pkg::BIT_SMARTCARD_EN];
    assign HALF_DUPLEX_OUT = mode_eff[umcg_pkg::BIT_HALF_DUPLEX_EN];
    assign IR_ENABLE_OUT = mode_eff[umcg_pkg::BIT_IR_EN];
    assign IR_LOW_POWER_OUT = mode_eff[umcg_pkg::BIT_IR_EN]
        && mode_eff[umcg_pkg::BIT_IR_LOW_POWER];
    assign IR_LP_TICK_OUT = lp_tick;
    assign CARD_CLK_OUT = st_r.card_clk;
    assign DMA_TX_REQ_OUT = st_r.dma_tx;
    assign DMA_RX_REQ_OUT = st_r.dma_rx;
    assign IRQ_OUT = |(st_r.stat & st_r.mask & {1'b1, 1'b1, 1'b1,
        mode_eff[umcg_pkg::BIT_CTS_IRQ_EN]}
        & {1'b1, 1'b1, 1'b1, 1'b1}
        & {1'b1, 1'b1, mode_eff[umcg_pkg::BIT_ERR_IRQ_EN], 1'b1});
endmodule

// file: hw/umcg_pkg.sv
// Purpose: shared constants of the serial mode-control and guard/prescale slice
// Assumes: 32-bit APB, one word per register
// Notes: reset values of both registers are all zero
package umcg_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MODE_CONTROL_THREE = 8'h14;
    localparam logic [7:0] ADDR_GUARD_AND_PRESCALE = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_LINK_STATUS = 8'h24;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // mode_control_three fields
    localparam int MC_WIDTH = 11;
    localparam int BIT_CTS_IRQ_EN = 10;
    localparam int BIT_CTS_FLOW_EN = 9;
    localparam int BIT_RTS_FLOW_EN = 8;
    localparam int BIT_DMA_TX_EN = 7;
    localparam int BIT_DMA_RX_EN = 6;
    localparam int BIT_SMARTCARD_EN = 5;
    localparam int BIT_SC_NACK_EN = 4;
    localparam int BIT_HALF_DUPLEX_EN = 3;
    localparam int BIT_IR_LOW_POWER = 2;
    localparam int BIT_IR_EN = 1;
    localparam int BIT_ERR_IRQ_EN = 0;
    // guard_and_prescale fields
    localparam int GT_WIDTH = 16;
    localparam int GUARD_LSB = 8;
    localparam int PSC_LSB = 0;
    localparam int SC_PSC_BITS = 5;
    // interrupt status bits
    localparam int IRQ_BITS = 4;
    localparam int IRQ_CTS = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_TXC = 2;
    localparam int IRQ_NACK = 3;
endpackage

// file: hw/umcg_clkdiv.sv
// Purpose: programmable divider giving a one-cycle enable pulse
// Assumes: divisor of zero is treated as one
// Notes: a new divisor applies at once to the count in progress
`timescale 1ns/1ps
module umcg_clkdiv (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic run_in,
    input wire logic [8:0] div_in,
    // pulse
    output logic tick_out
);
    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } umcg_div_t;
    umcg_div_t st_r;
    umcg_div_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run_in) begin
            st_nxt.cnt = 9'h000;
        end else if (st_r.cnt + 9'h001 >= div_in) begin
            st_nxt.cnt = 9'h000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;
endmodule

// file: hw/umcg_guard.sv
// Purpose: smartcard guard-time delay of the transmit-complete flag
// Assumes: frame end and baud tick come from the frame engine on this clock
// Notes: a zero guard value passes the flag on at once
`timescale 1ns/1ps
module umcg_guard (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic enable_in,
    input wire logic [7:0] guard_in,
    input wire logic baud_tick_in,
    input wire logic frame_done_in,
    // result
    output logic txc_set_out
);
    typedef struct packed {
        logic busy;
        logic [7:0] left;
        logic done;
    } umcg_grd_t;
    umcg_grd_t st_r;
    umcg_grd_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (frame_done_in) begin
            if (!enable_in || guard_in == 8'h00) begin
                st_nxt.done = 1'b1;
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.busy = 1'b1;
                st_nxt.left = guard_in;
            end
        end else if (st_r.busy && baud_tick_in) begin
            if (st_r.left == 8'h01) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
            st_nxt.left = st_r.left - 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign txc_set_out = st_r.done;
endmodule

// file: testbench/umcg_chk.sv
// Purpose: timing checks on the mode-control slice ports
// Assumes: one clock, synchronous active-high reset
// Notes: register bits that do not reach a port are checked by the bench
`timescale 1ns/1ps
module umcg_chk (
    // watched inputs
    input wire logic REF_CLK_IN, SRST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
    input wire logic CTS_N_IN, CTS_CHANGE_IN, FRAMING_ERR_IN, OVERRUN_ERR_IN,
    input wire logic NOISE_ERR_IN, PARITY_ERR_IN, FRAME_DONE_IN, RX_FULL_IN, TX_EMPTY_IN,
    // watched outputs
    input wire logic TX_ALLOWED_OUT, TX_COMPLETE_SET_OUT, SEND_NACK_OUT, SMARTCARD_MODE_OUT,
    input wire logic IR_ENABLE_OUT, IR_LOW_POWER_OUT, IR_LP_TICK_OUT, CARD_CLK_OUT,
    input wire logic DMA_TX_REQ_OUT, DMA_RX_REQ_OUT, IRQ_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SRST_IN);
    a_nack_cause: assert property (SEND_NACK_OUT |-> $past(PARITY_ERR_IN && SMARTCARD_MODE_OUT))
        else $error("nack without parity error");
    // cts passes two sync flops before it gates the sender
    a_flow_gate: assert property (!TX_ALLOWED_OUT |-> $past(CTS_N_IN, 2))
        else $error("send held while cts low");
    a_dma_tx_req: assert property (DMA_TX_REQ_OUT |-> $past(TX_EMPTY_IN))
        else $error("tx request without empty");
    a_dma_rx_req: assert property (DMA_RX_REQ_OUT |-> $past(RX_FULL_IN))
        else $error("rx request without full");
    a_txc_plain: assert property (FRAME_DONE_IN && !SMARTCARD_MODE_OUT |=> TX_COMPLETE_SET_OUT)
        else $error("complete late outside smartcard");
    a_card_idle: assert property (!SMARTCARD_MODE_OUT && !$past(SMARTCARD_MODE_OUT) |-> !CARD_CLK_OUT)
        else $error("card clock outside smartcard");
    a_lp_tick_mode: assert property (IR_LP_TICK_OUT |-> $past(IR_ENABLE_OUT && IR_LOW_POWER_OUT))
        else $error("low-power tick outside mode");
    a_irq_cause: assert property ($rose(IRQ_OUT) |-> $past(CTS_CHANGE_IN | FRAMING_ERR_IN
        | OVERRUN_ERR_IN | NOISE_ERR_IN | PARITY_ERR_IN | FRAME_DONE_IN | SEND_NACK_OUT
        | TX_COMPLETE_SET_OUT | (PSEL_IN & PENABLE_IN & PWRITE_IN)))
        else $error("interrupt without event");
    c_nack: cover property (SEND_NACK_OUT);
    c_card: cover property ($rose(CARD_CLK_OUT));
    c_guard: cover property (FRAME_DONE_IN && SMARTCARD_MODE_OUT ##[1:300] TX_COMPLETE_SET_OUT);
endmodule
bind umcg_top umcg_chk chk (.*);

// file: testbench/umcg_peer.sv
// Purpose: modem-side peer on the flow-control pins
// Assumes: peer reacts one clock after a change
// Notes: stopped_out shows the peer honouring a raised request-to-send
`timescale 1ns/1ps
module umcg_peer (
    // clock and control
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic busy_in,
    // pins
    input wire logic rts_n_in,
    output logic cts_n_out,
    output logic stopped_out
);
    always_ff @(posedge clk_in) begin
        cts_n_out <= srst_in ? 1'h0 : busy_in;
        stopped_out <= rts_n_in;
    end
endmodule

// file: testbench/umcg_top_tb.sv
// Purpose: register and mode checks of the mode-control slice
// Assumes: zero-wait APB slave, event pulses one clock long
// Notes: prescaler is never written zero, reserved bits stay zero
`timescale 1ns/1ps
module umcg_top_tb;
    logic REF_CLK_IN = 1'h0;
    logic SRST_IN = 1'h1;
    logic PSEL_IN = 1'h0;
    logic PENABLE_IN = 1'h0;
    logic PWRITE_IN = 1'h0;
    logic [7:0] PADDR_IN = 8'h00;
    logic [31:0] PWDATA_IN = 32'h0;
    logic [6:0] ev = 7'h00;
    logic RX_FULL_IN = 1'h0;
    logic TX_EMPTY_IN = 1'h0;
    logic RX_READY_IN = 1'h1;
    logic busy = 1'h0;
    logic CTS_N_IN, RTS_N_OUT, stopped, PREADY_OUT, PSLVERR_OUT, TX_ALLOWED_OUT;
    logic TX_COMPLETE_SET_OUT, SEND_NACK_OUT, SMARTCARD_MODE_OUT, HALF_DUPLEX_OUT;
    logic IR_ENABLE_OUT, IR_LOW_POWER_OUT, IR_LP_TICK_OUT, CARD_CLK_OUT, clk_q;
    logic DMA_TX_REQ_OUT, DMA_RX_REQ_OUT, IRQ_OUT;
    logic [31:0] PRDATA_OUT, q;
    logic lite_rts, lite_tx_ok, lite_sc, lite_card;
    wire CTS_CHANGE_IN = ev[0];
    wire FRAMING_ERR_IN = ev[1];
    wire OVERRUN_ERR_IN = ev[2];
    wire NOISE_ERR_IN = ev[3];
    wire PARITY_ERR_IN = ev[4];
    wire FRAME_DONE_IN = ev[5];
    wire BAUD_TICK_IN = ev[6];
    int err_count, compares, cycles, nack_n, txc_n, tick_n, rise_n, s;

    umcg_top dut (.*);
    umcg_peer peer (.clk_in(REF_CLK_IN), .srst_in(SRST_IN), .busy_in(busy),
        .rts_n_in(RTS_N_OUT), .cts_n_out(CTS_N_IN), .stopped_out(stopped));
    // reduced instance on the same bus and pins; its advanced bits must stay inert
    umcg_top #(.FULL_FEATURE(1'b0)) lite (.REF_CLK_IN(REF_CLK_IN), .SRST_IN(SRST_IN),
        .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
        .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(), .PREADY_OUT(), .PSLVERR_OUT(),
        .CTS_N_IN(CTS_N_IN), .RTS_N_OUT(lite_rts), .CTS_CHANGE_IN(CTS_CHANGE_IN),
        .FRAMING_ERR_IN(FRAMING_ERR_IN), .OVERRUN_ERR_IN(OVERRUN_ERR_IN),
        .NOISE_ERR_IN(NOISE_ERR_IN), .PARITY_ERR_IN(PARITY_ERR_IN),
        .FRAME_DONE_IN(FRAME_DONE_IN), .BAUD_TICK_IN(BAUD_TICK_IN), .RX_FULL_IN(RX_FULL_IN),
        .TX_EMPTY_IN(TX_EMPTY_IN), .RX_READY_IN(RX_READY_IN), .TX_ALLOWED_OUT(lite_tx_ok),
        .TX_COMPLETE_SET_OUT(), .SEND_NACK_OUT(), .SMARTCARD_MODE_OUT(lite_sc),
        .HALF_DUPLEX_OUT(), .IR_ENABLE_OUT(), .IR_LOW_POWER_OUT(), .IR_LP_TICK_OUT(),
        .CARD_CLK_OUT(lite_card), .DMA_TX_REQ_OUT(), .DMA_RX_REQ_OUT(), .IRQ_OUT());

    initial begin
        forever #20 REF_CLK_IN = ~REF_CLK_IN;
    end

    task stop_test;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // pulse counters sample on the falling edge, clear of the rising-edge stimulus steps
    always @(negedge REF_CLK_IN) begin
        cycles++;
        if (SEND_NACK_OUT === 1'h1) nack_n++;
        if (TX_COMPLETE_SET_OUT === 1'h1) txc_n++;
        if (IR_LP_TICK_OUT === 1'h1) tick_n++;
        if (CARD_CLK_OUT === 1'h1 && clk_q === 1'h0) rise_n++;
        clk_q = CARD_CLK_OUT;
        if (cycles == 4000) begin
            err_count++;
            stop_test;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK_IN);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // one apb transfer, then an idle cycle so the next setup is a fresh edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL_IN <= 1'h1;
        PWRITE_IN <= w;
        PADDR_IN <= a;
        PWDATA_IN <= d;
        cyc(1);
        PENABLE_IN <= 1'h1;
        // only the bench cycle ceiling limits this wait
        do begin
            cyc(1);
        end while (PREADY_OUT !== 1'h1);
        q = PRDATA_OUT;
        chk(PSLVERR_OUT, 1'h0);
        PSEL_IN <= 1'h0;
        PENABLE_IN <= 1'h0;
        cyc(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic pls(input int k);
        ev[k] <= 1'h1;
        cyc(1);
        ev[k] <= 1'h0;
        cyc(1);
    endtask

    initial begin
        cyc(16);
        SRST_IN <= 1'h0;
        cyc(1);
        rd(umcg_pkg::ADDR_MODE_CONTROL_THREE, umcg_pkg::RESET_VALUE);
        rd(umcg_pkg::ADDR_GUARD_AND_PRESCALE, umcg_pkg::RESET_VALUE);
        wr(8'h30, 32'hFFFF);
        rd(8'h30, 32'h0);
        wr(umcg_pkg::ADDR_GUARD_AND_PRESCALE, 32'h0305);
        rd(umcg_pkg::ADDR_GUARD_AND_PRESCALE, 32'h0305);
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h7FF);
        rd(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h7FF);
        chk({lite_sc, lite_card}, 2'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            // low-power output shows with infrared and low-power select set; infrared alone leaves it low
            wr(umcg_pkg::ADDR_MODE_CONTROL_THREE,
                (i == 0) ? 32'h20 : (i == 1) ? 32'h8 : (i == 2) ? 32'h6 : 32'h2);
            chk({SMARTCARD_MODE_OUT, HALF_DUPLEX_OUT, IR_LOW_POWER_OUT, IR_ENABLE_OUT},
                (i == 2) ? 4'h3 : 4'h8 >> i);
        end
        $display("test modes done");
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h30);
        s = nack_n;
        pls(4);
        chk(nack_n - s, 1);
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h20);
        pls(4);
        cyc(2);
        chk(nack_n - s, 1);
        cyc(12);
        s = rise_n;
        cyc(60);
        chk(rise_n - s, 6);
        s = txc_n;
        pls(5);
        pls(6);
        pls(6);
        cyc(3);
        chk(txc_n - s, 0);
        pls(6);
        cyc(3);
        chk(txc_n - s, 1);
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h0);
        pls(5);
        chk(txc_n - s, 2);
        $display("test smartcard done");
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h6);
        cyc(8);
        s = tick_n;
        cyc(50);
        chk(tick_n - s, 10);
        $display("test infrared done");
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h3C0);
        busy <= 1'h1;
        RX_FULL_IN <= 1'h1;
        TX_EMPTY_IN <= 1'h1;
        RX_READY_IN <= 1'h0;
        cyc(4);
        chk({TX_ALLOWED_OUT, stopped, DMA_TX_REQ_OUT, DMA_RX_REQ_OUT}, 4'h7);
        chk({lite_tx_ok, lite_rts}, 2'h2);
        RX_FULL_IN <= 1'h0;
        RX_READY_IN <= 1'h1;
        busy <= 1'h0;
        cyc(4);
        chk({TX_ALLOWED_OUT, stopped, DMA_RX_REQ_OUT}, 3'h4);
        busy <= 1'h1;
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h0);
        cyc(2);
        chk({TX_ALLOWED_OUT, DMA_TX_REQ_OUT}, 2'h2);
        busy <= 1'h0;
        $display("test flow done");
        // nack and the guarded and plain completions earlier left their sticky bits set
        rd(umcg_pkg::ADDR_IRQ_STATUS, 32'hC);
        wr(umcg_pkg::ADDR_IRQ_MASK, 32'hF);
        wr(umcg_pkg::ADDR_MODE_CONTROL_THREE, 32'h441);
        for (int k = 1; k < 4; k++) begin
            pls(k);
            chk(IRQ_OUT, 1'h1);
            rd(umcg_pkg::ADDR_IRQ_STATUS, 32'h2);
            chk(IRQ_OUT, 1'h0);
        end
        pls(0);
        chk(IRQ_OUT, 1'h1);
        rd(umcg_pkg::ADDR_IRQ_STATUS, 32'h1);
        wr(umcg_pkg::ADDR_IRQ_MASK, 32'h0);
        pls(1);
        cyc(2);
        chk(IRQ_OUT, 1'h0);
        rd(umcg_pkg::ADDR_IRQ_STATUS, 32'h2);
        $display("test interrupts done");
        stop_test;
    end
endmodule
